// ---- common/timer16_map.svh ----
// register offsets, field positions, reset values and prescaler masks of the 16-bit timer
// assumes a 32-bit APB slave; each printed offset is a word index, byte address = index * 4
// Function
// - Modes 1 to 3 count up and down to a fixed top of 0x00FF, 0x01FF or 0x03FF, load compare at top, overflow at bottom.
// - Mode 4 clears on a match with compare A as top, writes compare at once, overflow at max.
// - Modes 5 to 7 count up only to 0x00FF, 0x01FF or 0x03FF, load compare at bottom, overflow at top.
// - Modes 8 and 9 count up and down to the capture value or compare A, load compare and overflow at bottom.
// - Modes 10 and 11 count up and down to the capture value or compare A, load compare at top, overflow at bottom.
// - Mode 12 clears on a match with the capture value as top, writes compare at once, overflow at max.
// - Modes 14 and 15 count up only to the capture value or compare A, load compare at bottom, overflow at top.
// - The upper two mode bits sit in control B bits 4 and 3 and join the lower pair.
// - The lower two mode bits sit in control A bits 1:0 and form the 4-bit mode with the upper pair.
// - With the filter on, the capture input changes only after four equal samples in a row.
// - Edge select zero captures on a falling edge and one on a rising edge.
// - A capture edge copies the count into the capture register and sets the capture flag.
// - While the capture value is the top, the capture input is ignored.
// - Clock source 000 stops the counter and 001 to 101 divide the core clock by 1, 8, 64, 256 or 1024.
// - Clock source 110 counts falling and 111 rising edges of the external count pin.
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

// word indices
`define TMR_IDX_CTRL_A 8'h80
`define TMR_IDX_CTRL_B 8'h81
`define TMR_IDX_COUNT 8'h84
`define TMR_IDX_CAPTURE 8'h86
`define TMR_IDX_CMP_A 8'h88
`define TMR_IDX_INT_STATUS 8'h90
`define TMR_IDX_INT_MASK 8'h91

// field positions
`define TMR_A_MODE_LO 1:0
`define TMR_B_FILTER_EN 7
`define TMR_B_EDGE_SEL 6
`define TMR_B_MODE_HI 4:3
`define TMR_B_CLK_SEL 2:0
`define TMR_B_WRITE_MASK 8'hdf
`define TMR_INT_OVF 0
`define TMR_INT_CAPT 1
`define TMR_INT_CMPA 2

// reset values
`define TMR_CTRL_RESET 8'h00
`define TMR_WORD_RESET 16'h0000

// fixed tops
`define TMR_TOP_MAX 16'hffff
`define TMR_TOP_8BIT 16'h00ff
`define TMR_TOP_9BIT 16'h01ff
`define TMR_TOP_10BIT 16'h03ff

// prescaler tap masks
`define TMR_PRE_MASK_8 10'h007
`define TMR_PRE_MASK_64 10'h03f
`define TMR_PRE_MASK_256 10'h0ff
`define TMR_PRE_MASK_1024 10'h3ff

// cycles after reset before pin edges count
`define TMR_SETTLE_CYCLES 4'h8

`endif

// ---- common/timer16_pkg.sv ----
// types shared by the timer: mode decode result and count direction
// assumes timer16_map.svh is included by the users for the numbers
package timer16_pkg;

  typedef enum logic [1:0] {TOP_FIXED, TOP_CAPT, TOP_CMPA} top_src_t;
  typedef enum logic [1:0] {UPD_NOW, UPD_TOP, UPD_BOTTOM} upd_point_t;
  typedef enum logic [1:0] {OVF_MAX, OVF_TOP, OVF_BOTTOM} ovf_point_t;
  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

  typedef struct packed {
    top_src_t top_src;
    logic [15:0] fixed_top;
    logic dual_slope;
    upd_point_t upd;
    ovf_point_t ovf;
  } mode_cfg_t;

endpackage : timer16_pkg

// ---- design/timer16_mode_clk.sv ----
// 16-bit timer: mode decode, clock select, capture unit and APB register file
// assumes one core clock, async high reset, pins not synchronous to the core clock
`timescale 1ns/1ns
`include "timer16_map.svh"

module timer16_mode_clk (
  input wire logic CORE_CLK, // core clock, 125 MHz
  input wire logic RESET, // async reset, active high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready, no wait
  output logic PSLVERR, // unmapped address
  input wire logic CAPTURE_INPUT_PIN, // capture pin, asynchronous
  input wire logic EXTERNAL_COUNT_PIN, // external count pin, asynchronous
  output logic [15:0] COUNT_VALUE, // current count
  output logic IRQ // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // word index hit on an aligned address
  // misaligned or out-of-window addresses miss, which raises PSLVERR
  function automatic logic idx_hit(input logic [11:0] addr, input logic [7:0] idx);
    idx_hit = (addr[11:10] == 2'h0) && (addr[9:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : idx_hit

  // mode field to counting behaviour
  function automatic timer16_pkg::mode_cfg_t mode_decode(input logic [3:0] mode);
    timer16_pkg::mode_cfg_t c;
    c.top_src = timer16_pkg::TOP_FIXED;
    c.fixed_top = `TMR_TOP_MAX;
    c.dual_slope = 1'b0;
    c.upd = timer16_pkg::UPD_NOW;
    c.ovf = timer16_pkg::OVF_MAX;
    // defaults are plain 16-bit counting; each mode overrides only what differs
    case (mode)
      4'h1, 4'h2, 4'h3: begin
        c.dual_slope = 1'b1;
        c.fixed_top = (mode == 4'h1) ? `TMR_TOP_8BIT : (mode == 4'h2) ? `TMR_TOP_9BIT : `TMR_TOP_10BIT;
        c.upd = timer16_pkg::UPD_TOP;
        c.ovf = timer16_pkg::OVF_BOTTOM;
      end
      4'h4: c.top_src = timer16_pkg::TOP_CMPA;
      4'h5, 4'h6, 4'h7: begin
        c.fixed_top = (mode == 4'h5) ? `TMR_TOP_8BIT : (mode == 4'h6) ? `TMR_TOP_9BIT : `TMR_TOP_10BIT;
        c.upd = timer16_pkg::UPD_BOTTOM;
        c.ovf = timer16_pkg::OVF_TOP;
      end
      4'h8, 4'h9: begin
        c.top_src = mode[0] ? timer16_pkg::TOP_CMPA : timer16_pkg::TOP_CAPT;
        c.dual_slope = 1'b1;
        c.upd = timer16_pkg::UPD_BOTTOM;
        c.ovf = timer16_pkg::OVF_BOTTOM;
      end
      4'ha, 4'hb: begin
        c.top_src = mode[0] ? timer16_pkg::TOP_CMPA : timer16_pkg::TOP_CAPT;
        c.dual_slope = 1'b1;
        c.upd = timer16_pkg::UPD_TOP;
        c.ovf = timer16_pkg::OVF_BOTTOM;
      end
      4'hc: c.top_src = timer16_pkg::TOP_CAPT;
      4'he, 4'hf: begin
        c.top_src = mode[0] ? timer16_pkg::TOP_CMPA : timer16_pkg::TOP_CAPT;
        c.upd = timer16_pkg::UPD_BOTTOM;
        c.ovf = timer16_pkg::OVF_TOP;
      end
      // reserved 13 falls back to normal counting
      default: c.dual_slope = 1'b0;
    endcase
    mode_decode = c;
  endfunction : mode_decode

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [15:0] count;
  logic [15:0] capture_value_reg;
  logic [15:0] cmp_buf;
  logic [15:0] compare_a_value;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  timer16_pkg::dir_t dir;
  // prescaler is cleared only by reset, so a divided tick may come up to one period after selection
  logic [9:0] pre;
  logic cap_s1, cap_s2, cnt_s1, cnt_s2, cnt_prev;
  logic [3:0] cap_hist;
  logic cap_filt, cap_prev;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire [3:0] waveform_mode_sel = {ctrl_b[`TMR_B_MODE_HI], ctrl_a[`TMR_A_MODE_LO]};
  wire [2:0] clock_source_sel = ctrl_b[`TMR_B_CLK_SEL];
  wire capture_filter_en = ctrl_b[`TMR_B_FILTER_EN];
  wire capture_edge_sel = ctrl_b[`TMR_B_EDGE_SEL];
  timer16_pkg::mode_cfg_t cfg;
  assign cfg = mode_decode(waveform_mode_sel);

  wire [15:0] top = (cfg.top_src == timer16_pkg::TOP_CAPT) ? capture_value_reg :
                    (cfg.top_src == timer16_pkg::TOP_CMPA) ? compare_a_value : cfg.fixed_top;

  // apb decode
  wire acc = PSEL && PENABLE;
  wire setup = PSEL && !PENABLE;
  wire hit_a = idx_hit(PADDR, `TMR_IDX_CTRL_A);
  wire hit_b = idx_hit(PADDR, `TMR_IDX_CTRL_B);
  wire hit_cnt = idx_hit(PADDR, `TMR_IDX_COUNT);
  wire hit_cap = idx_hit(PADDR, `TMR_IDX_CAPTURE);
  wire hit_cmp = idx_hit(PADDR, `TMR_IDX_CMP_A);
  wire hit_ist = idx_hit(PADDR, `TMR_IDX_INT_STATUS);
  wire hit_imk = idx_hit(PADDR, `TMR_IDX_INT_MASK);
  wire hit_any = hit_a || hit_b || hit_cnt || hit_cap || hit_cmp || hit_ist || hit_imk;
  wire wr = acc && PWRITE;
  wire wr_cnt = wr && hit_cnt;
  wire wr_cmp = wr && hit_cmp;

  // every register answers in its access cycle: no wait states
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !hit_any;

  // read mux, bit 5 of control B is never stored so reads zero
  wire [31:0] rd_mux = hit_a ? {24'h000000, ctrl_a} :
                       hit_b ? {24'h000000, ctrl_b} :
                       hit_cnt ? {16'h0000, count} :
                       hit_cap ? {16'h0000, capture_value_reg} :
                       hit_cmp ? {16'h0000, cmp_buf} :
                       hit_ist ? {29'h00000000, int_status} :
                       hit_imk ? {29'h00000000, int_mask} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // edge arming after reset

  // a pin may idle high while its sampling flops reset low, which looks like an edge;
  // pin edges stay ignored until the synchronisers, the filter and the edge flops
  // all hold real pin samples
  logic [3:0] settle;
  wire armed = (settle == `TMR_SETTLE_CYCLES);
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      settle <= 4'h0;
    end else if (!armed) begin
      settle <= 4'(settle + 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock select

  // taps from one free-running prescaler, so divided ticks stay phase related
  // the count pin is sampled, so each level must last over one core cycle
  wire ext_fall = armed && cnt_prev && !cnt_s2;
  wire ext_rise = armed && !cnt_prev && cnt_s2;
  logic tick;
  always_comb begin
    case (clock_source_sel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (pre & `TMR_PRE_MASK_8) == `TMR_PRE_MASK_8;
      3'h3: tick = (pre & `TMR_PRE_MASK_64) == `TMR_PRE_MASK_64;
      3'h4: tick = (pre & `TMR_PRE_MASK_256) == `TMR_PRE_MASK_256;
      3'h5: tick = (pre & `TMR_PRE_MASK_1024) == `TMR_PRE_MASK_1024;
      3'h6: tick = ext_fall;
      default: tick = ext_rise;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter sequence

  wire at_top = (count == top);
  wire at_bottom = (count == 16'h0000);
  wire at_max = (count == `TMR_TOP_MAX);
  wire top_evt = tick && at_top;
  wire bottom_evt = tick && at_bottom;
  wire ovf_evt = (cfg.ovf == timer16_pkg::OVF_TOP) ? top_evt :
                 (cfg.ovf == timer16_pkg::OVF_BOTTOM) ? bottom_evt : (tick && at_max);
  wire upd_evt = (cfg.upd == timer16_pkg::UPD_TOP) ? top_evt :
                 (cfg.upd == timer16_pkg::UPD_BOTTOM) ? bottom_evt : 1'b1;
  wire cmpa_evt = tick && (count == compare_a_value);

  // a software write wins over a tick, so the written value is exact
  // single slope restarts when above top, so a lowered top never runs to max
  logic [15:0] next_count;
  timer16_pkg::dir_t next_dir;
  always_comb begin
    next_count = count;
    next_dir = dir;
    if (wr_cnt) begin
      next_count = PWDATA[15:0];
    end else if (tick && !cfg.dual_slope) begin
      next_count = (count >= top) ? 16'h0000 : 16'(count + 16'h0001);
      next_dir = timer16_pkg::DIR_UP;
    end else if (tick) begin
      case (dir)
        timer16_pkg::DIR_UP: begin
          if (count >= top && !at_bottom) begin
            next_count = 16'(count - 16'h0001);
            next_dir = timer16_pkg::DIR_DOWN;
          end else begin
            next_count = 16'(count + 16'h0001);
          end
        end
        timer16_pkg::DIR_DOWN: begin
          if (at_bottom) begin
            next_count = 16'(count + 16'h0001);
            next_dir = timer16_pkg::DIR_UP;
          end else begin
            next_count = 16'(count - 16'h0001);
          end
        end
        default: next_dir = timer16_pkg::DIR_UP;
      endcase
    end
  end

  // count and direction
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      count <= `TMR_WORD_RESET;
      dir <= timer16_pkg::DIR_UP;
      pre <= 10'h000;
    end else begin
      count <= next_count;
      dir <= next_dir;
      pre <= 10'(pre + 10'h001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare buffer

  // the active compare follows the buffer only at the mode's update point
  // limitation: a read of compare A returns the buffer, not the value in use
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      cmp_buf <= `TMR_WORD_RESET;
      compare_a_value <= `TMR_WORD_RESET;
    end else begin
      if (wr_cmp) begin
        cmp_buf <= PWDATA[15:0];
      end
      if (cfg.upd == timer16_pkg::UPD_NOW && wr_cmp) begin
        compare_a_value <= PWDATA[15:0];
      end else if (upd_evt) begin
        compare_a_value <= cmp_buf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and capture filter

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cnt_s1 <= 1'b0;
      cnt_s2 <= 1'b0;
      cnt_prev <= 1'b0;
    end else begin
      cap_s1 <= CAPTURE_INPUT_PIN;
      cap_s2 <= cap_s1;
      cnt_s1 <= EXTERNAL_COUNT_PIN;
      cnt_s2 <= cnt_s1;
      cnt_prev <= cnt_s2;
    end
  end

  // filter output moves only on four equal samples in a row
  // the history shifts even with the filter off, so turning it on gives no false edge
  wire cap_in = capture_filter_en ? cap_filt : cap_s2;
  wire cap_edge = capture_edge_sel ? (!cap_prev && cap_in) : (cap_prev && !cap_in);
  wire capt_evt = armed && cap_edge && (cfg.top_src != timer16_pkg::TOP_CAPT);
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      cap_hist <= 4'h0;
      cap_filt <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      cap_hist <= {cap_hist[2:0], cap_s2};
      if (&cap_hist || ~|cap_hist) begin
        cap_filt <= cap_hist[3];
      end
      cap_prev <= cap_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, capture and interrupt registers

  wire [2:0] int_set = {cmpa_evt, capt_evt, ovf_evt};
  wire [2:0] int_clr = (wr && hit_ist) ? PWDATA[2:0] : 3'h0;

  // a set in the clearing cycle wins over the write of one
  // a capture also wins over a software write to the capture register
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_a <= `TMR_CTRL_RESET;
      ctrl_b <= `TMR_CTRL_RESET;
      capture_value_reg <= `TMR_WORD_RESET;
      int_status <= 3'h0;
      int_mask <= 3'h0;
    end else begin
      if (wr && hit_a) begin
        ctrl_a <= PWDATA[7:0];
      end
      if (wr && hit_b) begin
        ctrl_b <= PWDATA[7:0] & `TMR_B_WRITE_MASK;
      end
      if (capt_evt) begin
        capture_value_reg <= count;
      end else if (wr && hit_cap) begin
        capture_value_reg <= PWDATA[15:0];
      end
      int_status <= (int_status & ~int_clr) | int_set;
      if (wr && hit_imk) begin
        int_mask <= PWDATA[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // read data latched in the setup cycle so PRDATA is a flop in the access phase
  // IRQ uses this cycle's set and clear, so it changes at the same edge as the flags
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h00000000;
      IRQ <= 1'b0;
    end else begin
      if (setup && !PWRITE) begin
        PRDATA <= rd_mux;
      end
      IRQ <= |((int_status & ~int_clr | int_set) & int_mask);
    end
  end

  assign COUNT_VALUE = count;

endmodule : timer16_mode_clk

// ---- testbench/timer16_mode_clk_monitor.sv ----
// checker of the timer's port behaviour, bound to the top module
// assumes registers change only by APB writes and pins rest during mode runs
`timescale 1ns/1ns

module timer16_mode_clk_monitor (
  input wire logic CORE_CLK, // clock
  input wire logic RESET, // reset
  input wire logic PSEL, // select
  input wire logic PENABLE, // access phase
  input wire logic PWRITE, // write
  input wire logic [11:0] PADDR, // address
  input wire logic [31:0] PWDATA, // write data
  input wire logic [31:0] PRDATA, // read data
  input wire logic PREADY, // ready
  input wire logic PSLVERR, // error
  input wire logic CAPTURE_INPUT_PIN, // capture pin
  input wire logic EXTERNAL_COUNT_PIN, // count pin
  input wire logic [15:0] COUNT_VALUE, // count
  input wire logic IRQ // interrupt
);
  logic [1:0] ca;
  logic [7:0] cb;
  logic [2:0] msk;
  logic wr_d;
  logic [15:0] cmpa;
  logic [15:0] icr;

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the shadowed setup; quiet skips cycles a write may still land in
  wire wr = PSEL && PENABLE && PWRITE;
  wire quiet = !wr && !wr_d;
  wire [3:0] mode = {cb[4:3], ca};
  wire run1 = cb[2:0] == 3'h1 && quiet;
  wire dual = mode inside {[4'h1:4'h3], [4'h8:4'hb]};
  wire mapped = PADDR inside {12'h200, 12'h204, 12'h210, 12'h218, 12'h220, 12'h240, 12'h244};
  wire [15:0] top = mode inside {4'h4, 4'h9, 4'hb, 4'hf} ? cmpa : mode inside {4'h8, 4'ha, 4'hc, 4'he} ? icr :
    mode inside {4'h1, 4'h5} ? 16'h00ff : mode inside {4'h2, 4'h6} ? 16'h01ff : 16'h03ff;

  // shadow of the setup registers, captures ignored since pins rest then
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ca <= 2'h0;
      cb <= 8'h00;
      msk <= 3'h0;
      wr_d <= 1'b0;
      cmpa <= 16'h0000;
      icr <= 16'h0000;
    end else begin
      wr_d <= wr;
      if (wr && PADDR == 12'h200) ca <= PWDATA[1:0];
      if (wr && PADDR == 12'h204) cb <= PWDATA[7:0];
      if (wr && PADDR == 12'h244) msk <= PWDATA[2:0];
      if (wr && PADDR == 12'h220) cmpa <= PWDATA[15:0];
      if (wr && PADDR == 12'h218) icr <= PWDATA[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking mon_clk @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  sequence at_top;
    run1 && COUNT_VALUE == top;
  endsequence
  sequence ext_edge;
    mode == 4'h0 && quiet && (cb[2:0] == 3'h7 && $rose(EXTERNAL_COUNT_PIN) ||
      cb[2:0] == 3'h6 && $fell(EXTERNAL_COUNT_PIN));
  endsequence

  AST_PREADY: assert property (PSEL && PENABLE |-> PREADY)
    else $error("access phase without ready");
  AST_SLVERR: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
    else $error("error response does not match the address map");
  AST_CLK_STOP: assert property (cb[2:0] == 3'h0 && quiet |=> $stable(COUNT_VALUE))
    else $error("count moved with no clock source");
  AST_DIV1: assert property (mode == 4'h0 && run1 && COUNT_VALUE != 16'hffff |=>
    COUNT_VALUE == $past(COUNT_VALUE) + 16'h1) else $error("undivided clock missed a step");
  AST_SINGLE_WRAP: assert property (!dual && !(mode inside {4'h0, 4'hd}) and at_top |=>
    COUNT_VALUE == 16'h0000) else $error("single slope did not restart at top");
  AST_DUAL_TURN: assert property (dual and at_top |=> COUNT_VALUE == $past(top) - 16'h1)
    else $error("dual slope did not turn down at top");
  AST_OVF_TOP: assert property (mode inside {[4'h5:4'h7], 4'he, 4'hf} && msk[0] and at_top |-> ##[1:2] IRQ)
    else $error("no overflow interrupt at top");
  AST_OVF_BOTTOM: assert property (dual && msk[0] && run1 && COUNT_VALUE == 16'h0000 |-> ##[1:2] IRQ)
    else $error("no overflow interrupt at bottom");
  AST_IRQ_MASKED: assert property (msk == 3'h0 && $past(msk) == 3'h0 |-> !IRQ)
    else $error("interrupt with every source masked");
  AST_EXT_EDGE: assert property (ext_edge |-> ##[2:4] COUNT_VALUE != $past(COUNT_VALUE))
    else $error("external edge not counted");
endmodule : timer16_mode_clk_monitor

// ---- testbench/timer16_mode_clk_tb.sv ----
// self-checking bench of the timer mode and clock select block
// assumes zero-wait APB slave and the pin partner model beside it
`timescale 1ns/1ns

module timer16_mode_clk_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] count;
  logic irq;
  logic cap_level = 1'b1;
  logic ext_go = 1'b0;
  logic cap_pin;
  logic ext_pin;
  int fail_count = 0;
  int compares = 0;
  logic [33:0] expq[$];
  logic [33:0] q;

  always #4 core_clk = ~core_clk;

  timer16_mode_clk dut_u (.CORE_CLK(core_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CAPTURE_INPUT_PIN(cap_pin), .EXTERNAL_COUNT_PIN(ext_pin), .COUNT_VALUE(count), .IRQ(irq));
  timer16_pins_model pins_u (.clk(core_clk), .cap_level(cap_level), .ext_go(ext_go), .cap_pin(cap_pin),
    .ext_pin(ext_pin));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // one APB transfer; holds everything until ready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait count is assumed; only the watchdog ends a stuck access
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, r);
  endtask : wr

  // expected result noted first, the watcher below compares it
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    logic [31:0] r;
    expq.push_back({1'b0, err, e});
    apb(a, 1'b0, 32'h0, r);
  endtask : rd

  task automatic peek(input logic [11:0] a, output logic [31:0] r);
    expq.push_back({1'b1, 33'h0});
    apb(a, 1'b0, 32'h0, r);
  endtask : peek

  // watcher: every completed read takes the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0) begin
      q = expq.pop_front();
      if (!q[33]) begin
        chk("read data", prdata, q[31:0]);
        chk("error flag", {31'h0, pslverr}, {31'h0, q[32]});
      end
    end
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [31:0] a0;
    logic [31:0] a1;
    int k;
    logic [3:0] modes[14] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
    int tops[14] = '{255, 511, 1023, 64, 255, 511, 1023, 64, 64, 64, 64, 64, 64, 64};
    int divs[6] = '{4, 1, 8, 64, 256, 1024};
    v = $urandom(32'hd668e3f7);
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(12'h204, 32'h0);
    rd(12'h200, 32'h0);
    rd(12'h300, 32'h0, 1'b1);
    wr(12'h220, 32'h40);
    wr(12'h218, 32'h40);
    wr(12'h244, 32'h1);
    // random setups; low mode bits 10 keep the reserved mode away
    for (k = 0; k < 4; k++) begin
      v = $urandom() & 32'hff;
      wr(12'h204, v);
      rd(12'h204, v & 32'hdf);
      v = ($urandom() & 32'hfc) | 32'h2;
      wr(12'h200, v);
      rd(12'h200, v);
    end
    // every mode except 0 and reserved 13, run past top and back to bottom
    foreach (modes[i]) begin
      wr(12'h204, 32'h0);
      wr(12'h210, 32'h0);
      wr(12'h240, 32'h7);
      wr(12'h200, {30'h0, modes[i][1:0]});
      wr(12'h204, {27'h0, modes[i][3:2], 3'h1});
      repeat (2 * tops[i] + 100) @(posedge core_clk);
    end
    // prescaler: ticks over exactly four periods
    wr(12'h204, 32'h0);
    wr(12'h200, 32'h0);
    wr(12'h210, 32'h0);
    for (k = 0; k < 6; k++) begin
      wr(12'h204, 32'(k));
      peek(12'h210, a0);
      repeat (divs[k] * 4 - 3) @(posedge core_clk);
      peek(12'h210, a1);
      chk("prescaled ticks", a1 - a0, (k == 0) ? 32'h0 : 32'h4);
    end
    // external pin, falling then rising
    for (k = 6; k < 8; k++) begin
      wr(12'h204, 32'(k));
      wr(12'h210, 32'h0);
      ext_go <= 1'b1;
      @(posedge core_clk);
      ext_go <= 1'b0;
      repeat (30) @(posedge core_clk);
      rd(12'h210, 32'h4);
    end
    // capture with counter stopped so the copied value is exact
    wr(12'h204, 32'h0);
    wr(12'h244, 32'h0);
    wr(12'h240, 32'h7);
    for (k = 0; k < 2; k++) begin
      wr(12'h204, 32'(k) << 6);
      wr(12'h210, 32'h1000 + 32'(k));
      cap_level <= ~k[0];
      repeat (12) @(posedge core_clk);
      cap_level <= k[0];
      repeat (12) @(posedge core_clk);
      rd(12'h218, 32'h1000 + 32'(k));
      wr(12'h210, 32'h2000);
      cap_level <= ~k[0];
      repeat (12) @(posedge core_clk);
      rd(12'h218, 32'h1000 + 32'(k));
    end
    rd(12'h240, 32'h2);
    wr(12'h244, 32'h2);
    repeat (2) @(negedge core_clk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    @(posedge core_clk);
    wr(12'h240, 32'h2);
    repeat (2) @(negedge core_clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    @(posedge core_clk);
    // filter: a three-sample glitch must not pass
    wr(12'h204, 32'hc0);
    wr(12'h210, 32'h3000);
    cap_level <= 1'b1;
    repeat (3) @(posedge core_clk);
    cap_level <= 1'b0;
    repeat (12) @(posedge core_clk);
    rd(12'h218, 32'h1001);
    cap_level <= 1'b1;
    repeat (12) @(posedge core_clk);
    rd(12'h218, 32'h3000);
    // capture value as top: pin ignored
    wr(12'h204, 32'h58);
    wr(12'h210, 32'h4000);
    cap_level <= 1'b0;
    repeat (12) @(posedge core_clk);
    cap_level <= 1'b1;
    repeat (12) @(posedge core_clk);
    rd(12'h218, 32'h3000);
    test_done();
  end
endmodule : timer16_mode_clk_tb

bind timer16_mode_clk timer16_mode_clk_monitor mon_u (.CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CAPTURE_INPUT_PIN, .EXTERNAL_COUNT_PIN, .COUNT_VALUE, .IRQ);

// ---- testbench/timer16_pins_model.sv ----
// partner: off-chip logic on the capture pin and the external count pin
// assumes bench requests arrive just after a rising edge of the core clock
`timescale 1ns/1ns

module timer16_pins_model (
  input wire logic clk, // core clock
  input wire logic cap_level, // wanted capture pin level
  input wire logic ext_go, // one-cycle start of an edge burst
  output logic cap_pin, // capture pin
  output logic ext_pin // external count pin
);
  int left = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // pins lag one cycle; count pin stands low between bursts
  initial cap_pin = 1'b1;
  initial ext_pin = 1'b0;
  always @(posedge clk) begin
    cap_pin <= cap_level;
    if (ext_go) left <= 16;
    else if (left > 0) left <= left - 1;
    // two cycles a phase so the synchroniser never misses one
    if (left > 0 && left % 2 == 0) ext_pin <= ~ext_pin;
  end
endmodule : timer16_pins_model
